// ===== design/flash_seq_pkg.sv
// constants, types and register map shared by the flash command sequencer
package flash_seq_pkg;

    ////////////////////////////////////////////////////////////////////////
    // clock and timing
    localparam int unsigned CLK_MHZ = 100;
    // single-cycle core: one machine cycle is one core clock
    localparam int unsigned CLKS_PER_MC = 1;
    localparam int unsigned US_PER_MS = 1000;
    localparam int unsigned READ_PAGE_MC = 25;
    localparam int unsigned VERIFY_PAGE_MC = 25;
    localparam int unsigned READ_BYTE_MC = 10;
    localparam int unsigned WRITE_PAGE_US = 380;
    localparam int unsigned WRITE_BYTE_US = 200;
    localparam int unsigned ERASE_PAGE_MS = 2;
    localparam int unsigned ERASE_ALL_MS = 2;
    localparam int unsigned USER_LOAD_MODE_WRITE_PAGE_MS = 15;
    localparam int unsigned TIMER_W = 21;
    typedef logic [TIMER_W-1:0] count_type;

    ////////////////////////////////////////////////////////////////////////
    // special function register addresses
    localparam logic [7:0] SFR_CMD = 8'hB9;
    localparam logic [7:0] SFR_ADDR_LOW = 8'hC6;
    localparam logic [7:0] SFR_ADDR_HIGH = 8'hC7;
    localparam logic [7:0] SFR_DATA1 = 8'hBC;
    localparam logic [7:0] SFR_DATA2 = 8'hBD;
    localparam logic [7:0] SFR_DATA3 = 8'hBE;
    localparam logic [7:0] SFR_DATA4 = 8'hBF;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [7:0] UNMAPPED_BYTE = 8'h00;

    ////////////////////////////////////////////////////////////////////////
    // command codes and verify answers
    localparam logic [7:0] CMD_READ_PAGE = 8'h01;
    localparam logic [7:0] CMD_WRITE_PAGE = 8'h02;
    localparam logic [7:0] CMD_VERIFY = 8'h04;
    localparam logic [7:0] CMD_ERASE_PAGE = 8'h05;
    localparam logic [7:0] CMD_ERASE_ALL = 8'h06;
    localparam logic [7:0] CMD_READ_BYTE = 8'h81;
    localparam logic [7:0] CMD_WRITE_BYTE = 8'h82;
    localparam logic [7:0] CMD_NORMAL = 8'h0F;
    localparam logic [7:0] CMD_USER_LOAD = 8'hF0;
    localparam logic [7:0] VERIFY_OK = 8'h00;
    localparam logic [7:0] VERIFY_BAD = 8'h01;

    ////////////////////////////////////////////////////////////////////////
    // array geometry and address limits
    localparam int unsigned DATA_PAGES = 1024;
    localparam logic [9:0] LAST_PAGE = 10'h3FF;
    localparam logic [15:0] PAGE_LIMIT = 16'h0400;
    localparam logic [15:0] DATA_BYTE_LIMIT = 16'h1000;
    localparam logic [7:0] USER_LOAD_MODE_PAGE_LIMIT = 8'hE0;
    localparam logic [15:0] USER_LOAD_MODE_BYTE_LAST = 16'hDFFF;
    localparam logic [15:0] USER_LOAD_MODE_ERASE_MASK = 16'hFFC0;
    localparam logic [31:0] ERASED_WORD = 32'hFFFF_FFFF;
    localparam logic [8:0] COPY_LAST = 9'h1FF;

    typedef enum logic {
        ST_IDLE = 1'b0,
        ST_WAIT = 1'b1
    } seq_state_type;

endpackage

// ===== design/op_timer.sv
// down counter that times one array operation
`timescale 1ns/10ps
module op_timer (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic load,
    input wire flash_seq_pkg::count_type loadValue,
    output logic done
);

    typedef struct packed {
        flash_seq_pkg::count_type count;
    } timer_regs_type;

    timer_regs_type state_r;
    timer_regs_type state_nxt;

    always_comb
    begin
        state_nxt = state_r;
        if (load)
        begin
            state_nxt.count = loadValue;
        end
        else if (state_r.count != '0)
        begin
            state_nxt.count = state_r.count - 1'b1;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            state_r <= '0;
        end
        else
        begin
            state_r <= state_nxt;
        end
    end

    assign done = (state_r.count == '0);

endmodule

// ===== design/flash_command_sequencer.sv
// command sequencer for the data flash array and user-load program flash
`timescale 1ns/10ps
// Contract
// - page read fills the four data registers
// - page write stores data registers below 0400H
// - user-load page write copies 256 RAM bytes
// - verify leaves zero on match, nonzero otherwise
// - user-load read, verify, byte read do nothing
// - page erase clears one four-byte page
// - user-load page erase clears 64-byte page
// - erase all clears whole array of mode
// - byte read loads first data register
// - byte write stores first data register
// - code 0FH selects normal mode
// - code F0H selects user-load mode
// - normal mode after reset
// - address registers give high and low byte
// - normal page operation durations
// - normal byte operation durations
// - user-load operation durations
// - command write starts the operation at once
// - core held until operation completes
// - peripherals keep running during the hold
// - data array is 1024 four-byte pages
// - only lower 56 kbytes programmable in user-load
module flash_command_sequencer #(
    parameter int unsigned WRITE_PAGE_CLKS = flash_seq_pkg::WRITE_PAGE_US * flash_seq_pkg::CLK_MHZ,
    parameter int unsigned WRITE_BYTE_CLKS = flash_seq_pkg::WRITE_BYTE_US * flash_seq_pkg::CLK_MHZ,
    parameter int unsigned ERASE_PAGE_CLKS =
        flash_seq_pkg::ERASE_PAGE_MS * flash_seq_pkg::US_PER_MS * flash_seq_pkg::CLK_MHZ,
    parameter int unsigned ERASE_ALL_CLKS =
        flash_seq_pkg::ERASE_ALL_MS * flash_seq_pkg::US_PER_MS * flash_seq_pkg::CLK_MHZ,
    parameter int unsigned USER_LOAD_MODE_WRITE_PAGE_CLKS =
        flash_seq_pkg::USER_LOAD_MODE_WRITE_PAGE_MS * flash_seq_pkg::US_PER_MS * flash_seq_pkg::CLK_MHZ
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic sfrWrEn,
    input wire logic [7:0] sfrAddr,
    input wire logic [7:0] sfrWrData,
    output logic [7:0] sfrRdData,
    output logic coreHold,
    output logic userLoadMode,
    output logic [15:0] pmAddr,
    output logic [7:0] pmWrData,
    output logic pmWrEn,
    output logic pmErasePage,
    output logic pmEraseAll,
    output logic [7:0] xramAddr,
    input wire logic [7:0] xramRdData
);

    localparam int unsigned READ_PAGE_CLKS = flash_seq_pkg::READ_PAGE_MC * flash_seq_pkg::CLKS_PER_MC;
    localparam int unsigned VERIFY_PAGE_CLKS = flash_seq_pkg::VERIFY_PAGE_MC * flash_seq_pkg::CLKS_PER_MC;
    localparam int unsigned READ_BYTE_CLKS = flash_seq_pkg::READ_BYTE_MC * flash_seq_pkg::CLKS_PER_MC;

    typedef struct packed {
        flash_seq_pkg::seq_state_type st;
        logic userLoad;
        logic [7:0] cmd;
        logic [7:0] op;
        logic [7:0] addrHigh;
        logic [7:0] addrLow;
        logic [3:0][7:0] pageData;
        logic [9:0] wipeIdx;
        logic wipeDone;
        logic [8:0] copyIdx;
        logic copyDone;
        logic [15:0] pmAddr;
        logic [7:0] pmWrData;
        logic pmWrEn;
        logic pmErasePage;
        logic pmEraseAll;
        logic [7:0] xramAddr;
        logic [7:0] rdData;
    } seq_regs_type;

    seq_regs_type state_r;
    seq_regs_type state_nxt;

    ////////////////////////////////////////////////////////////////////////
    // data flash array, one 32-bit word per four-byte page
    logic [31:0] dataMem [flash_seq_pkg::DATA_PAGES];
    logic memWe;
    logic [9:0] memIdx;
    logic [31:0] memWord;
    logic [31:0] memRd;
    logic [9:0] rdIdx;

    logic [15:0] flashAddr;
    logic pageOk;
    logic byteOk;
    logic ulByteOk;
    logic [1:0] byteLane;
    logic byteOp;
    logic cmdTaken;
    logic startOp;
    flash_seq_pkg::count_type startCount;
    logic timerDone;

    assign flashAddr = {state_r.addrHigh, state_r.addrLow};
    assign pageOk = (flashAddr < flash_seq_pkg::PAGE_LIMIT);
    assign byteOk = (flashAddr < flash_seq_pkg::DATA_BYTE_LIMIT);
    assign ulByteOk = (flashAddr <= flash_seq_pkg::USER_LOAD_MODE_BYTE_LAST);
    assign byteLane = state_r.addrLow[1:0];
    assign byteOp = (state_r.op == flash_seq_pkg::CMD_READ_BYTE) || (state_r.op == flash_seq_pkg::CMD_WRITE_BYTE);
    assign rdIdx = byteOp ? flashAddr[11:2] : flashAddr[9:0];
    assign memRd = dataMem[rdIdx];
    assign cmdTaken = sfrWrEn && (sfrAddr == flash_seq_pkg::SFR_CMD) && (state_r.st == flash_seq_pkg::ST_IDLE);

    always_ff @(posedge core_clk)
    begin
        if (memWe)
        begin
            dataMem[memIdx] <= memWord;
        end
    end

    op_timer timer (
        .core_clk(core_clk),
        .rst(rst),
        .load(startOp),
        .loadValue(startCount),
        .done(timerDone)
    );

    ////////////////////////////////////////////////////////////////////////
    // next state
    always_comb
    begin
        state_nxt = state_r;
        state_nxt.pmWrEn = 1'b0;
        state_nxt.pmErasePage = 1'b0;
        state_nxt.pmEraseAll = 1'b0;
        startOp = 1'b0;
        startCount = '0;
        memWe = 1'b0;
        memIdx = rdIdx;
        memWord = memRd;

        // register writes; the core is held while busy, so only idle writes land
        if (sfrWrEn && (state_r.st == flash_seq_pkg::ST_IDLE))
        begin
            case (sfrAddr)
                flash_seq_pkg::SFR_ADDR_HIGH: state_nxt.addrHigh = sfrWrData;
                flash_seq_pkg::SFR_ADDR_LOW: state_nxt.addrLow = sfrWrData;
                flash_seq_pkg::SFR_DATA1: state_nxt.pageData[0] = sfrWrData;
                flash_seq_pkg::SFR_DATA2: state_nxt.pageData[1] = sfrWrData;
                flash_seq_pkg::SFR_DATA3: state_nxt.pageData[2] = sfrWrData;
                flash_seq_pkg::SFR_DATA4: state_nxt.pageData[3] = sfrWrData;
                flash_seq_pkg::SFR_CMD: state_nxt.cmd = sfrWrData;
                default:
                begin
                end
            endcase
        end

        // command decode; reserved and unknown codes fall to default
        if (cmdTaken)
        begin
            case (sfrWrData)
                flash_seq_pkg::CMD_NORMAL: state_nxt.userLoad = 1'b0;
                flash_seq_pkg::CMD_USER_LOAD: state_nxt.userLoad = 1'b1;
                flash_seq_pkg::CMD_READ_PAGE:
                begin
                    startOp = !state_r.userLoad;
                    startCount = flash_seq_pkg::count_type'(READ_PAGE_CLKS - 1);
                end
                flash_seq_pkg::CMD_VERIFY:
                begin
                    startOp = !state_r.userLoad;
                    startCount = flash_seq_pkg::count_type'(VERIFY_PAGE_CLKS - 1);
                end
                flash_seq_pkg::CMD_READ_BYTE:
                begin
                    startOp = !state_r.userLoad;
                    startCount = flash_seq_pkg::count_type'(READ_BYTE_CLKS - 1);
                end
                flash_seq_pkg::CMD_WRITE_PAGE:
                begin
                    startOp = 1'b1;
                    if (state_r.userLoad)
                    begin
                        startCount = flash_seq_pkg::count_type'(USER_LOAD_MODE_WRITE_PAGE_CLKS - 1);
                    end
                    else
                    begin
                        startCount = flash_seq_pkg::count_type'(WRITE_PAGE_CLKS - 1);
                    end
                end
                flash_seq_pkg::CMD_ERASE_PAGE:
                begin
                    startOp = 1'b1;
                    startCount = flash_seq_pkg::count_type'(ERASE_PAGE_CLKS - 1);
                    // user-load page erase is issued at once to the program array
                    state_nxt.pmErasePage = state_r.userLoad && ulByteOk;
                    if (state_r.userLoad && ulByteOk)
                    begin
                        state_nxt.pmAddr = flashAddr & flash_seq_pkg::USER_LOAD_MODE_ERASE_MASK;
                    end
                end
                flash_seq_pkg::CMD_ERASE_ALL:
                begin
                    startOp = 1'b1;
                    startCount = flash_seq_pkg::count_type'(ERASE_ALL_CLKS - 1);
                    state_nxt.pmEraseAll = state_r.userLoad;
                end
                flash_seq_pkg::CMD_WRITE_BYTE:
                begin
                    startOp = 1'b1;
                    startCount = flash_seq_pkg::count_type'(WRITE_BYTE_CLKS - 1);
                    if (state_r.userLoad && ulByteOk)
                    begin
                        state_nxt.pmWrEn = 1'b1;
                        state_nxt.pmAddr = flashAddr;
                        state_nxt.pmWrData = state_r.pageData[0];
                    end
                end
                default:
                begin
                end
            endcase
        end

        // the operation begins in the cycle after the command write
        if (startOp)
        begin
            state_nxt.st = flash_seq_pkg::ST_WAIT;
            state_nxt.op = sfrWrData;
            state_nxt.wipeIdx = '0;
            state_nxt.wipeDone = !((sfrWrData == flash_seq_pkg::CMD_ERASE_ALL) && !state_r.userLoad);
            state_nxt.copyIdx = '0;
            state_nxt.copyDone = !((sfrWrData == flash_seq_pkg::CMD_WRITE_PAGE) && state_r.userLoad
                && (state_r.addrHigh < flash_seq_pkg::USER_LOAD_MODE_PAGE_LIMIT));
        end

        unique case (state_r.st)
            flash_seq_pkg::ST_IDLE:
            begin
            end
            flash_seq_pkg::ST_WAIT:
            begin
                // whole data array erase walks one page per cycle
                if (!state_r.wipeDone)
                begin
                    memWe = 1'b1;
                    memIdx = state_r.wipeIdx;
                    memWord = flash_seq_pkg::ERASED_WORD;
                    state_nxt.wipeIdx = state_r.wipeIdx + 1'b1;
                    state_nxt.wipeDone = (state_r.wipeIdx == flash_seq_pkg::LAST_PAGE);
                end
                // expanded RAM to program page: address phase, then write phase
                if (!state_r.copyDone)
                begin
                    if (!state_r.copyIdx[0])
                    begin
                        state_nxt.xramAddr = state_r.copyIdx[8:1];
                    end
                    else
                    begin
                        state_nxt.pmWrEn = 1'b1;
                        state_nxt.pmAddr = {state_r.addrHigh, state_r.xramAddr};
                        state_nxt.pmWrData = xramRdData;
                    end
                    state_nxt.copyIdx = state_r.copyIdx + 1'b1;
                    state_nxt.copyDone = (state_r.copyIdx == flash_seq_pkg::COPY_LAST);
                end
                if (timerDone && state_r.wipeDone && state_r.copyDone)
                begin
                    state_nxt.st = flash_seq_pkg::ST_IDLE;
                    if (!state_r.userLoad)
                    begin
                        case (state_r.op)
                            flash_seq_pkg::CMD_READ_PAGE:
                            begin
                                if (pageOk)
                                begin
                                    state_nxt.pageData = memRd;
                                end
                            end
                            flash_seq_pkg::CMD_VERIFY:
                            begin
                                if (pageOk && (memRd == state_r.pageData))
                                begin
                                    state_nxt.cmd = flash_seq_pkg::VERIFY_OK;
                                end
                                else
                                begin
                                    state_nxt.cmd = flash_seq_pkg::VERIFY_BAD;
                                end
                            end
                            flash_seq_pkg::CMD_WRITE_PAGE:
                            begin
                                memWe = pageOk;
                                memWord = state_r.pageData;
                            end
                            flash_seq_pkg::CMD_ERASE_PAGE:
                            begin
                                memWe = pageOk;
                                memWord = flash_seq_pkg::ERASED_WORD;
                            end
                            flash_seq_pkg::CMD_READ_BYTE:
                            begin
                                if (byteOk)
                                begin
                                    state_nxt.pageData[0] = memRd[byteLane * 8 +: 8];
                                end
                            end
                            flash_seq_pkg::CMD_WRITE_BYTE:
                            begin
                                memWe = byteOk;
                                memWord[byteLane * 8 +: 8] = state_r.pageData[0];
                            end
                            default:
                            begin
                            end
                        endcase
                    end
                end
            end
        endcase

        // read data is registered: it shows the addressed register next cycle
        case (sfrAddr)
            flash_seq_pkg::SFR_CMD: state_nxt.rdData = state_nxt.cmd;
            flash_seq_pkg::SFR_ADDR_HIGH: state_nxt.rdData = state_nxt.addrHigh;
            flash_seq_pkg::SFR_ADDR_LOW: state_nxt.rdData = state_nxt.addrLow;
            flash_seq_pkg::SFR_DATA1: state_nxt.rdData = state_nxt.pageData[0];
            flash_seq_pkg::SFR_DATA2: state_nxt.rdData = state_nxt.pageData[1];
            flash_seq_pkg::SFR_DATA3: state_nxt.rdData = state_nxt.pageData[2];
            flash_seq_pkg::SFR_DATA4: state_nxt.rdData = state_nxt.pageData[3];
            default: state_nxt.rdData = flash_seq_pkg::UNMAPPED_BYTE;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            state_r <= '0;
            state_r.st <= flash_seq_pkg::ST_IDLE;
            state_r.cmd <= flash_seq_pkg::RESET_BYTE;
            state_r.wipeDone <= 1'b1;
            state_r.copyDone <= 1'b1;
        end
        else
        begin
            state_r <= state_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs; only instruction fetch is held, timers are not gated here
    assign coreHold = (state_r.st == flash_seq_pkg::ST_WAIT);
    assign userLoadMode = state_r.userLoad;
    assign sfrRdData = state_r.rdData;
    assign pmAddr = state_r.pmAddr;
    assign pmWrData = state_r.pmWrData;
    assign pmWrEn = state_r.pmWrEn;
    assign pmErasePage = state_r.pmErasePage;
    assign pmEraseAll = state_r.pmEraseAll;
    assign xramAddr = state_r.xramAddr;

endmodule

// ===== sim/flash_seq_chk.sv
// port assertions for the flash command sequencer
`timescale 1ns/10ps
module flash_seq_chk (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic sfrWrEn,
    input wire logic [7:0] sfrAddr,
    input wire logic [7:0] sfrWrData,
    input wire logic coreHold,
    input wire logic userLoadMode,
    input wire logic [15:0] pmAddr,
    input wire logic pmWrEn,
    input wire logic pmErasePage
);
    logic go;
    logic [7:0] cmd_r;
    logic [11:0] cnt_r;
    assign go = sfrWrEn && !coreHold && sfrAddr == flash_seq_pkg::SFR_CMD;
    // remembers the running command and counts its hold cycles
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            cmd_r <= 8'h00;
            cnt_r <= 12'h000;
        end
        else
        begin
            cmd_r <= go ? sfrWrData : cmd_r;
            cnt_r <= coreHold ? cnt_r + 12'h001 : 12'h000;
        end
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    a_page_read_time: assert property ($fell(coreHold) && !userLoadMode
        && (cmd_r == 8'h01 || cmd_r == 8'h04) |-> cnt_r == 12'h019) else $error("page read or verify hold length");
    a_byte_read_time: assert property ($fell(coreHold) && !userLoadMode && cmd_r == 8'h81
        |-> cnt_r == 12'h00A) else $error("byte read hold length");
    a_cmd_start: assert property (go && !userLoadMode && sfrWrData == 8'h01 |=> coreHold)
        else $error("command did not start at once");
    a_enter_user_load_mode: assert property (go && sfrWrData == 8'hF0 |=> userLoadMode)
        else $error("user-load mode not entered");
    a_leave_user_load_mode: assert property (go && sfrWrData == 8'h0F |=> !userLoadMode)
        else $error("normal mode not entered");
    a_reset_normal: assert property ($past(rst) |-> !userLoadMode && !coreHold)
        else $error("not idle in normal mode after reset");
    a_user_load_mode_noop: assert property (go && userLoadMode && sfrWrData inside {8'h01, 8'h04, 8'h81}
        |=> !coreHold) else $error("unsupported user-load code started work");
    a_reserved_code: assert property (go && sfrWrData == 8'h03
        |=> !coreHold && $stable(userLoadMode)) else $error("reserved code had an effect");
    a_erase_align: assert property (pmErasePage |-> pmAddr[5:0] == 6'h00 && userLoadMode)
        else $error("program page erase misaligned");
    a_user_load_mode_limit: assert property (pmWrEn |-> pmAddr <= 16'hDFFF && userLoadMode)
        else $error("program write outside user-load region");
endmodule
bind flash_command_sequencer flash_seq_chk i_chk (.core_clk(core_clk), .rst(rst), .sfrWrEn(sfrWrEn),
    .sfrAddr(sfrAddr), .sfrWrData(sfrWrData), .coreHold(coreHold), .userLoadMode(userLoadMode),
    .pmAddr(pmAddr), .pmWrEn(pmWrEn), .pmErasePage(pmErasePage));

// ===== sim/flash_far_side.sv
// expanded RAM and program flash model facing the sequencer
`timescale 1ns/10ps
module flash_far_side (
    input wire logic core_clk,
    input wire logic [15:0] pmAddr,
    input wire logic [7:0] pmWrData,
    input wire logic pmWrEn,
    input wire logic pmErasePage,
    input wire logic pmEraseAll,
    input wire logic [7:0] xramAddr,
    output logic [7:0] xramRdData
);
    logic [7:0] mem [0:65535];
    logic [15:0] erAddr = 16'h0000;
    int nWr = 0;
    int nErase = 0;
    assign xramRdData = xramAddr ^ 8'h5A;
    always @(posedge core_clk)
    begin
        if (pmWrEn)
        begin
            // programming only clears bits, so unerased cells stay wrong
            mem[pmAddr] = mem[pmAddr] & pmWrData;
            nWr++;
        end
        if (pmErasePage)
        begin
            for (int i = 0; i < 64; i++) mem[pmAddr + 16'(i)] = 8'hFF;
            erAddr = pmAddr;
            nErase++;
        end
        if (pmEraseAll)
        begin
            for (int i = 0; i < 57344; i++) mem[i] = 8'hFF;
            nErase++;
        end
    end
endmodule

// ===== sim/flash_command_sequencer_bench.sv
// self-checking bench for the flash command sequencer
`timescale 1ns/10ps
module flash_command_sequencer_bench;
    localparam logic [7:0] CMD = flash_seq_pkg::SFR_CMD;
    localparam logic [7:0] AH = flash_seq_pkg::SFR_ADDR_HIGH;
    localparam logic [7:0] AL = flash_seq_pkg::SFR_ADDR_LOW;
    localparam logic [7:0] D1 = flash_seq_pkg::SFR_DATA1;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic sfrWrEn = 1'b0;
    logic [7:0] sfrAddr = 8'h00;
    logic [7:0] sfrWrData = 8'h00;
    logic [7:0] sfrRdData, xramAddr, xramRdData, pmWrData;
    logic coreHold, userLoadMode, pmWrEn, pmErasePage, pmEraseAll;
    logic [15:0] pmAddr;
    logic [7:0] nopCodes [3] = '{8'h01, 8'h04, 8'h81};
    int mismatches = 0;
    int nCompared = 0;
    always #5 core_clk = ~core_clk;
    flash_command_sequencer #(.WRITE_PAGE_CLKS(50), .WRITE_BYTE_CLKS(40), .ERASE_PAGE_CLKS(60),
        .ERASE_ALL_CLKS(60), .USER_LOAD_MODE_WRITE_PAGE_CLKS(600)) i_dut (.core_clk(core_clk), .rst(rst),
        .sfrWrEn(sfrWrEn), .sfrAddr(sfrAddr), .sfrWrData(sfrWrData), .sfrRdData(sfrRdData),
        .coreHold(coreHold), .userLoadMode(userLoadMode), .pmAddr(pmAddr), .pmWrData(pmWrData),
        .pmWrEn(pmWrEn), .pmErasePage(pmErasePage), .pmEraseAll(pmEraseAll), .xramAddr(xramAddr),
        .xramRdData(xramRdData));
    flash_far_side i_far (.core_clk(core_clk), .pmAddr(pmAddr), .pmWrData(pmWrData), .pmWrEn(pmWrEn),
        .pmErasePage(pmErasePage), .pmEraseAll(pmEraseAll), .xramAddr(xramAddr), .xramRdData(xramRdData));
    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        nCompared++;
        if (got !== exp)
        begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        #1;
        sfrWrEn = 1'b1;
        sfrAddr = a;
        sfrWrData = d;
        @(posedge core_clk);
        #1;
        sfrWrEn = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge core_clk);
        #1;
        sfrAddr = a;
        @(posedge core_clk);
        #1;
        check(sfrRdData, exp);
    endtask
    // counts the remaining hold cycles of a running command
    task automatic hold(input int n);
        int k;
        k = 0;
        while (coreHold === 1'b1 && k < 3000)
        begin
            @(posedge core_clk);
            #1;
            k++;
        end
        check(k, n);
    endtask
    task automatic cmd(input logic [7:0] c, input int n);
        wr(CMD, c);
        hold(n);
    endtask
    task automatic complete_run();
        $display("compared %0d mismatches %0d", nCompared, mismatches);
        if (mismatches == 0 && nCompared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        #200000;
        mismatches++;
        complete_run();
    end
    initial
    begin
        repeat (2) @(posedge core_clk);
        #1;
        rst = 1'b0;
        check(userLoadMode, 1'b0);
        rd(CMD, 8'h00);
        rd(8'h00, 8'h00);
        wr(AH, 8'h00);
        wr(AL, 8'h03);
        cmd(8'h06, 1025);
        cmd(8'h01, 25);
        for (int i = 0; i < 4; i++) rd(D1 + 8'(i), 8'hFF);
        for (int i = 0; i < 4; i++) wr(D1 + 8'(i), 8'h11 * 8'(i + 1));
        cmd(8'h02, 50);
        for (int i = 0; i < 4; i++) wr(D1 + 8'(i), 8'h00);
        cmd(8'h01, 25);
        for (int i = 0; i < 4; i++) rd(D1 + 8'(i), 8'h11 * 8'(i + 1));
        cmd(8'h04, 25);
        rd(CMD, flash_seq_pkg::VERIFY_OK);
        wr(D1 + 8'h01, 8'h55);
        cmd(8'h04, 25);
        rd(CMD, flash_seq_pkg::VERIFY_BAD);
        wr(CMD, 8'h05);
        wr(D1, 8'h77);
        hold(58);
        rd(D1, 8'h11);
        wr(AL, 8'h0D);
        cmd(8'h81, 10);
        rd(D1, 8'hFF);
        wr(D1, 8'hA5);
        cmd(8'h82, 40);
        wr(AL, 8'h03);
        cmd(8'h01, 25);
        rd(D1 + 8'h01, 8'hA5);
        rd(D1 + 8'h02, 8'hFF);
        cmd(8'h03, 0);
        rd(CMD, 8'h03);
        check(userLoadMode, 1'b0);
        cmd(8'hF0, 0);
        check(userLoadMode, 1'b1);
        for (int i = 0; i < 3; i++) cmd(nopCodes[i], 0);
        cmd(8'h06, 60);
        check(i_far.nErase, 1);
        wr(AH, 8'hC0);
        wr(AL, 8'h85);
        cmd(8'h05, 60);
        check(i_far.erAddr, 16'hC080);
        wr(AH, 8'h12);
        wr(AL, 8'h34);
        rd(AL, 8'h34);
        wr(D1, 8'h3C);
        cmd(8'h82, 40);
        check(i_far.mem[16'h1234], 8'h3C);
        wr(AH, 8'hE0);
        wr(AL, 8'h00);
        cmd(8'h82, 40);
        check(i_far.nWr, 1);
        wr(AH, 8'h05);
        cmd(8'h02, 600);
        check(i_far.nWr, 257);
        check(i_far.mem[16'h0500], 8'h5A);
        check(i_far.mem[16'h05FF], 8'hA5);
        cmd(8'h0F, 0);
        check(userLoadMode, 1'b0);
        complete_run();
    end
endmodule
